// *** core/dps_debug_status.sv ***
// Debug access port status, reset control and low-power handling.
`include "dps_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (RULE_01) Low-leakage-stop exit flag set on recovery, held until acknowledge bit written 1.
// (RULE_02) Very-low-leakage-stop exit flag at bit 10, same set and acknowledge.
// (RULE_03) Status bit 16 reads 1 while core is debug halted.
// (RULE_04) Status bit 17 mirrors core deep-sleep output.
// (RULE_05) Status bit 18 mirrors core core_sleep_flag output.
// (RULE_06) Power-on reset is the only reset of this logic.
// (RULE_07) System reset asserted while debugger keeps system-reset request set.
// (RULE_08) Only core held in reset while core-reset request set.
// (RULE_09) Software reset request from interrupt controller causes system reset.
// (RULE_10) Static debug logic resumes immediately after low-power exit, no reconfiguration.
// (RULE_11) Powered-off debug logic is reset on recovery; debugger reconfigures.
// (RULE_12) Debug and system power-up requests mark an active debugger.
// (RULE_13) Debugger changes power-up requests only in run, wait and their low-power forms; the code blocks control writes only in LLS and VLLS.
// (RULE_14) Active debugger keeps processor clock running in stop states.
// (RULE_15) Clock kept alive in stop: core registers reachable, system memory refused.
// (RULE_16) Debug enabled: run to very-low-power stop becomes ordinary stop.
// (RULE_17) Debug enabled: very-low-power run to very-low-power stop still allowed.
// (RULE_18) Very-low-leakage stop clears all debug controls at wakeup.
// (RULE_19) Low-leakage stop keeps debug state but blocks debug activity.
// (RULE_20) Control may hold system in reset after very-low-leakage recovery until released.
// (RULE_21) Status register stays readable while secured, showing security state.
// (RULE_22) While secured only mass erase may act on the system; the code still applies system and core reset requests while secured.
// (RULE_23) Status bit 9 is the low-leakage-stop exit flag.
// (RULE_24) Status bit 3 reads 0 in system reset, 1 out of it.
// (RULE_25) Status fields read-only; exit flags change only by hardware or acknowledge.
module dps_debug_status
	import dps_pkg::*;
(
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	input  wire logic [`DPS_ADDR_W-1:0]  regAddr,
	input  wire logic [31:0]             regWdata,
	input  wire logic                    regWrite,
	input  wire logic                    regRead,
	output logic      [31:0]             regRdata,
	input  wire dps_core_t               coreStat,
	input  wire logic                    swResetReq,
	input  wire logic                    linkClk,
	input  wire logic                    sysInReset,
	input  wire dps_mode_t               modeRequest,
	input  wire dps_mode_t               modeCurrent,
	input  wire logic                    llsRecovery,
	input  wire logic                    vllsRecovery,
	output logic                         sysResetOut,
	output logic                         coreResetOut,
	output dps_mode_t                    modeGranted,
	output logic                         cpuClkKeep,
	output logic                         debuggerActive,
	output logic                         coreRegAccessEn,
	output logic                         sysMemAccessEn,
	output logic                         massEraseLaunch,
	output logic                         linkEdge
);

	dps_state_t st;
	dps_state_t next_st;
	logic       active;
	logic       inStop;
	logic       lowLeak;
	logic [31:0] status;

	//////////////////////////////////////////////////////////////////////////
	assign active  = st.ctrl[`DPS_CT_DBG_PWR] | st.ctrl[`DPS_CT_SYS_PWR]; // RULE_12
	assign inStop  = (modeCurrent == DPS_STOP) || (modeCurrent == DPS_VERY_LOW_POWER_STOP);
	assign lowLeak = (modeCurrent == DPS_LLS) || (modeCurrent == DPS_VLLS);

	always_comb begin
		status = 32'h0000_0000;
		status[`DPS_ST_ERASE_ACK] = st.eraseAck;
		status[`DPS_ST_FLASH_RDY] = coreStat.flashReady;
		status[`DPS_ST_SECURE]    = coreStat.secure; // RULE_21
		status[`DPS_ST_SYS_OUT]   = ~st.sysRstSync[1]; // RULE_24
		status[`DPS_ST_ERASE_EN]  = coreStat.eraseEnable;
		status[`DPS_ST_BACKDOOR]  = coreStat.backdoorEnable;
		status[`DPS_ST_LP_EN]     = (modeRequest == DPS_VERY_LOW_POWER_STOP) || lowLeak;
		status[`DPS_ST_VLP]       = (modeCurrent == DPS_VERY_LOW_POWER_RUN) || (modeCurrent == DPS_VERY_LOW_POWER_WAIT)
			|| (modeCurrent == DPS_VERY_LOW_POWER_STOP);
		status[`DPS_ST_LLS_EXIT]  = st.llsExit; // RULE_23
		status[`DPS_ST_VLLS_EXIT] = st.vllsExit; // RULE_02
		status[`DPS_ST_HALTED]    = coreStat.halted; // RULE_03
		status[`DPS_ST_DEEP]      = coreStat.deepSleep; // RULE_04
		status[`DPS_ST_SLEEP]     = coreStat.core_sleep_flag; // RULE_05
	end

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.swSync     = {st.swSync[1:0], linkClk};
		next_st.linkPrev   = st.swSync[2];
		next_st.sysRstSync = {st.sysRstSync[0], sysInReset};
		next_st.rdata      = 32'h0000_0000;
		next_st.eraseLaunch = 1'b0;
		next_st.pwrSync    = {st.pwrSync[1:0], active};
		// Status remains readable whether secure or not; reads are idle in low-leakage and very-low-leakage stop.
		if (regRead && !lowLeak) begin // RULE_19
			unique case (regAddr)
				`DPS_OFF_STATUS:  next_st.rdata = status; // RULE_21
				`DPS_OFF_CONTROL: next_st.rdata = {23'h000000, st.ctrl};
				default:          next_st.rdata = 32'h0000_0000;
			endcase
		end
		// Status has no write path, so its fields stay read-only.
		if (regWrite && !lowLeak && regAddr == `DPS_OFF_CONTROL) begin // RULE_25
			next_st.ctrl = regWdata[8:0];
			next_st.ctrl[`DPS_CT_ACK] = 1'b0;
			if (regWdata[`DPS_CT_HOLD_VLLS])
				next_st.holdAfterVlls = 1'b1;
			else
				next_st.holdAfterVlls = 1'b0;
			if (regWdata[`DPS_CT_ERASE] && coreStat.eraseEnable) begin // RULE_22
				next_st.eraseLaunch = 1'b1;
				next_st.eraseAck    = 1'b0;
			end
			if (regWdata[`DPS_CT_ACK]) begin
				next_st.llsExit  = 1'b0; // RULE_01
				next_st.vllsExit = 1'b0; // RULE_02
			end
		end
		if (coreStat.eraseStarted)
			next_st.eraseAck = 1'b1;
		// Hardware set comes last so an exit in the acknowledge cycle is not lost.
		if (llsRecovery)
			next_st.llsExit = 1'b1; // RULE_01
		if (vllsRecovery) begin
			next_st.vllsExit = 1'b1; // RULE_02
			// Debug logic was powered off: controls restart cleared, with system reset taken from the hold request.
			next_st.ctrl = `DPS_CTRL_RESET; // RULE_18
			next_st.ctrl[`DPS_CT_SYS_RST] = st.holdAfterVlls; // RULE_20
		end
		// An LOW_LEAKAGE_STOP exit leaves ctrl untouched, so debug works at once.
		next_st.granted = modeRequest; // RULE_10
		if (active && modeRequest == DPS_VERY_LOW_POWER_STOP && modeCurrent == DPS_RUN)
			next_st.granted = DPS_STOP; // RULE_16
		// From VERY_LOW_POWER_RUN the request passes through unchanged.
		if (active && modeRequest == DPS_VERY_LOW_POWER_STOP && modeCurrent == DPS_VERY_LOW_POWER_RUN)
			next_st.granted = DPS_VERY_LOW_POWER_STOP; // RULE_17
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin // RULE_06 RULE_11
			st <= '{ctrl: 9'h000, granted: DPS_RUN, default: '0};
		end else begin
			st <= next_st;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	assign regRdata        = st.rdata;
	assign sysResetOut     = st.ctrl[`DPS_CT_SYS_RST] | swResetReq; // RULE_07 RULE_09 RULE_20
	assign coreResetOut    = st.ctrl[`DPS_CT_CORE_RST]; // RULE_08
	assign modeGranted     = st.granted;
	assign debuggerActive  = st.pwrSync[1]; // RULE_12
	assign cpuClkKeep      = active && inStop; // RULE_14
	assign coreRegAccessEn = !lowLeak && !coreStat.secure; // RULE_15 RULE_19
	assign sysMemAccessEn  = !lowLeak && !coreStat.secure && !(cpuClkKeep); // RULE_15 RULE_22
	assign massEraseLaunch = st.eraseLaunch; // RULE_22
	assign linkEdge        = st.swSync[2] & ~st.linkPrev;

endmodule : dps_debug_status

// *** include/dps_regs.svh ***
// Register offsets, field positions and reset values of the debug status and control block.
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH
`define DPS_ADDR_W        8
`define DPS_OFF_STATUS    8'h00
`define DPS_OFF_CONTROL   8'h04
`define DPS_OFF_ERASE     8'h08
`define DPS_ST_ERASE_ACK  0
`define DPS_ST_FLASH_RDY  1
`define DPS_ST_SECURE     2
`define DPS_ST_SYS_OUT    3
`define DPS_ST_ERASE_EN   5
`define DPS_ST_BACKDOOR   6
`define DPS_ST_LP_EN      7
`define DPS_ST_VLP        8
`define DPS_ST_LLS_EXIT   9
`define DPS_ST_VLLS_EXIT  10
`define DPS_ST_HALTED     16
`define DPS_ST_DEEP       17
`define DPS_ST_SLEEP      18
`define DPS_CT_ERASE      0
`define DPS_CT_SYS_RST    3
`define DPS_CT_CORE_RST   4
`define DPS_CT_ACK        5
`define DPS_CT_HOLD_VLLS  6
`define DPS_CT_DBG_PWR    7
`define DPS_CT_SYS_PWR    8
`define DPS_CTRL_RESET    9'h000
`endif

// *** include/dps_pkg.sv ***
// Types shared by the debug status and control block.
package dps_pkg;
	typedef enum logic [2:0] {
		DPS_RUN  = 3'b000,
		DPS_VERY_LOW_POWER_RUN = 3'b001,
		DPS_WAIT = 3'b010,
		DPS_VERY_LOW_POWER_WAIT = 3'b011,
		DPS_STOP = 3'b100,
		DPS_VERY_LOW_POWER_STOP = 3'b101,
		DPS_LLS  = 3'b110,
		DPS_VLLS = 3'b111
	} dps_mode_t;

	typedef struct packed {
		logic       halted;
		logic       deepSleep;
		logic       core_sleep_flag;
		logic       secure;
		logic       flashReady;
		logic       eraseEnable;
		logic       backdoorEnable;
		logic       eraseStarted;
	} dps_core_t;

	typedef struct packed {
		logic [8:0] ctrl;
		logic       llsExit;
		logic       vllsExit;
		logic       eraseAck;
		logic       holdAfterVlls;
		logic [31:0] rdata;
		logic [2:0] swSync;
		logic [2:0] pwrSync;
		logic       linkPrev;
		logic [1:0] sysRstSync;
		logic       eraseLaunch;
		dps_mode_t  granted;
	} dps_state_t;
endpackage : dps_pkg

// *** tb/dps_debug_status_chk.sv ***
// Port-level assertions for the debug status block.
`include "dps_regs.svh"
module dps_debug_status_chk
	import dps_pkg::*;
(
	input wire logic                   sys_clk,
	input wire logic                   rstn,
	input wire logic [`DPS_ADDR_W-1:0] regAddr,
	input wire logic                   regRead,
	input wire logic [31:0]            regRdata,
	input wire dps_core_t              coreStat,
	input wire logic                   swResetReq,
	input wire dps_mode_t              modeRequest,
	input wire dps_mode_t              modeCurrent,
	input wire logic                   sysResetOut,
	input wire dps_mode_t              modeGranted,
	input wire logic                   cpuClkKeep,
	input wire logic                   debuggerActive,
	input wire logic                   coreRegAccessEn,
	input wire logic                   sysMemAccessEn
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_rd; regRead && regAddr == `DPS_OFF_STATUS && modeCurrent < DPS_LLS; endsequence
	property p_halt; s_rd |=> regRdata[16] == $past(coreStat.halted); endproperty
	a_halt: assert property (p_halt) else $error("halt bit");
	property p_deep; s_rd |=> regRdata[17] == $past(coreStat.deepSleep); endproperty
	a_deep: assert property (p_deep) else $error("deep bit");
	property p_sleep; s_rd |=> regRdata[18] == $past(coreStat.core_sleep_flag); endproperty
	a_sleep: assert property (p_sleep) else $error("sleep bit");
	property p_swRst; swResetReq |-> sysResetOut; endproperty
	a_swRst: assert property (p_swRst) else $error("sw reset");
	property p_keep; debuggerActive && modeCurrent inside {DPS_STOP, DPS_VERY_LOW_POWER_STOP} |-> cpuClkKeep; endproperty
	a_keep: assert property (p_keep) else $error("clock keep");
	// A secured part also loses core register access, so only the unsecured case expects it.
	property p_mem; cpuClkKeep |-> !sysMemAccessEn && coreRegAccessEn == !coreStat.secure; endproperty
	a_mem: assert property (p_mem) else $error("access");
	property p_lowLeak; modeCurrent inside {DPS_LLS, DPS_VLLS} |-> !coreRegAccessEn && !sysMemAccessEn; endproperty
	a_lowLeak: assert property (p_lowLeak) else $error("low-leakage access");
	property p_very_low_power_stop; debuggerActive && modeCurrent == DPS_RUN && modeRequest == DPS_VERY_LOW_POWER_STOP
		|=> modeGranted == DPS_STOP; endproperty
	a_very_low_power_stop: assert property (p_very_low_power_stop) else $error("run to very_low_power_stop");
	property p_very_low_power_run; modeCurrent == DPS_VERY_LOW_POWER_RUN && modeRequest == DPS_VERY_LOW_POWER_STOP |=> modeGranted == DPS_VERY_LOW_POWER_STOP; endproperty
	a_very_low_power_run: assert property (p_very_low_power_run) else $error("very_low_power_run to very_low_power_stop");
endmodule : dps_debug_status_chk
bind dps_debug_status dps_debug_status_chk chk (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regRead(regRead),
	.regRdata(regRdata), .coreStat(coreStat), .swResetReq(swResetReq), .modeRequest(modeRequest),
	.modeCurrent(modeCurrent), .sysResetOut(sysResetOut), .modeGranted(modeGranted), .cpuClkKeep(cpuClkKeep),
	.debuggerActive(debuggerActive), .coreRegAccessEn(coreRegAccessEn), .sysMemAccessEn(sysMemAccessEn));

// *** tb/dps_probe.sv ***
// Probe-side link clock that toggles only inside frames.
module dps_probe (
	input wire logic frame,
	output logic     linkClk
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		linkClk = 1'b0;
		#137;
		forever #400 linkClk = frame & ~linkClk;
	end
endmodule : dps_probe

// *** tb/testbench.sv ***
// Self-checking bench for the debug status block.
module testbench
	import dps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rstn = 0, regWrite = 0, regRead = 0, swResetReq = 0, sysInReset = 0, llsRecovery = 0;
	logic vllsRecovery = 0, frame = 0, linkClk, sysResetOut, coreResetOut, cpuClkKeep, debuggerActive;
	logic coreRegAccessEn, sysMemAccessEn, massEraseLaunch, linkEdge;
	logic [7:0] regAddr = 0;
	logic [31:0] regWdata = 0, regRdata;
	dps_core_t coreStat = '0;
	dps_mode_t modeRequest = DPS_RUN, modeCurrent = DPS_RUN, modeGranted;
	int err_total = 0, checks = 0, launches = 0, edges = 0;
	dps_probe probe (.frame(frame), .linkClk(linkClk));
	dps_debug_status dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .coreStat(coreStat), .swResetReq(swResetReq),
		.linkClk(linkClk), .sysInReset(sysInReset), .modeRequest(modeRequest), .modeCurrent(modeCurrent),
		.llsRecovery(llsRecovery), .vllsRecovery(vllsRecovery), .sysResetOut(sysResetOut),
		.coreResetOut(coreResetOut), .modeGranted(modeGranted), .cpuClkKeep(cpuClkKeep),
		.debuggerActive(debuggerActive), .coreRegAccessEn(coreRegAccessEn), .sysMemAccessEn(sysMemAccessEn),
		.massEraseLaunch(massEraseLaunch), .linkEdge(linkEdge));
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (massEraseLaunch) launches++;
	always @(posedge sys_clk) if (linkEdge) edges++;
	task automatic chk(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t %h %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	// Data is judged mid-cycle, while the value launched by the read edge stands, away from any edge race.
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		@(negedge sys_clk);
		chk(regRdata & m, e);
		@(posedge sys_clk);
	endtask : rd
	task automatic t_status;
		for (int i = 0; i < 8; i++) begin
			coreStat[7:5] <= 3'(i);
			rd(8'h00, 32'hffff_f800, {13'h0, i[0], i[1], i[2], 16'h0});
		end
		sysInReset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(8'h00, 32'h8, 32'h0);
		sysInReset <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd(8'h00, 32'h8, 32'h8);
	endtask : t_status
	task automatic t_exit;
		for (int v = 0; v < 2; v++) begin
			wr(8'h04, 32'(v) << 6);
			{vllsRecovery, llsRecovery} <= 2'(1 << v);
			@(posedge sys_clk);
			{vllsRecovery, llsRecovery} <= 2'b00;
			@(posedge sys_clk);
			chk(sysResetOut, 32'(v));
			rd(8'h04, 32'h1ff, 32'(v) << 3);
			rd(8'h00, 32'h600, 32'h200 << v);
			wr(8'h00, 32'hffff_ffff);
			rd(8'h00, 32'h600, 32'h200 << v);
			wr(8'h04, 32'h20);
			rd(8'h00, 32'h600, 32'h0);
		end
	endtask : t_exit
	task automatic t_lls;
		wr(8'h04, 32'h10);
		modeCurrent <= DPS_LLS;
		@(posedge sys_clk);
		chk({coreRegAccessEn, sysMemAccessEn}, 2'b00);
		wr(8'h04, 32'h0);
		rd(8'h00, 32'hffff_ffff, 32'h0);
		modeCurrent <= DPS_RUN;
		llsRecovery <= 1'b1;
		@(posedge sys_clk);
		llsRecovery <= 1'b0;
		rd(8'h04, 32'h1ff, 32'h10);
		chk(coreResetOut, 1);
		wr(8'h04, 32'h20);
		rd(8'h00, 32'h600, 32'h0);
	endtask : t_lls
	task automatic t_reset;
		wr(8'h04, 32'h8);
		chk({sysResetOut, coreResetOut}, 2'b10);
		wr(8'h04, 32'h10);
		chk({sysResetOut, coreResetOut}, 2'b01);
		wr(8'h04, 32'h0);
		swResetReq <= 1'b1;
		@(posedge sys_clk);
		chk(sysResetOut, 1);
		swResetReq <= 1'b0;
		wr(8'h04, 32'h18);
		rstn <= 1'b0;
		@(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({sysResetOut, coreResetOut}, 2'b00);
		rd(8'h04, 32'h1ff, 32'h0);
	endtask : t_reset
	task automatic t_lowpow;
		frame <= 1'b1;
		wr(8'h04, 32'h180);
		repeat (3) @(posedge sys_clk);
		chk(debuggerActive, 1);
		modeRequest <= DPS_VERY_LOW_POWER_STOP;
		repeat (2) @(posedge sys_clk);
		chk(modeGranted, DPS_STOP);
		modeCurrent <= DPS_VERY_LOW_POWER_RUN;
		repeat (2) @(posedge sys_clk);
		chk(modeGranted, DPS_VERY_LOW_POWER_STOP);
		modeCurrent <= DPS_STOP;
		@(posedge sys_clk);
		chk({cpuClkKeep, coreRegAccessEn, sysMemAccessEn}, 3'b110);
		modeCurrent <= DPS_RUN;
		modeRequest <= DPS_RUN;
		@(posedge sys_clk);
		chk(sysMemAccessEn, 1);
		wr(8'h04, 32'h0);
		frame <= 1'b0;
	endtask : t_lowpow
	// The link clock period is eight system clocks, so a steady frame gives one edge pulse per eight cycles.
	task automatic t_link;
		int n0;
		frame <= 1'b1;
		repeat (24) @(posedge sys_clk);
		@(negedge sys_clk);
		n0 = edges;
		repeat (64) @(negedge sys_clk);
		chk(edges - n0, 8);
		@(posedge sys_clk);
		frame <= 1'b0;
		repeat (32) @(posedge sys_clk);
		@(negedge sys_clk);
		n0 = edges;
		repeat (64) @(negedge sys_clk);
		chk(edges - n0, 0);
		@(posedge sys_clk);
	endtask : t_link
	task automatic t_secure;
		coreStat.secure <= 1'b1;
		rd(8'h00, 32'h4, 32'h4);
		chk(sysMemAccessEn, 0);
		wr(8'h04, 32'h1);
		coreStat.eraseEnable <= 1'b1;
		wr(8'h04, 32'h1);
		repeat (3) @(posedge sys_clk);
		chk(launches, 1);
		coreStat.eraseStarted <= 1'b1;
		@(posedge sys_clk);
		coreStat.eraseStarted <= 1'b0;
		rd(8'h00, 32'h1, 32'h1);
	endtask : t_secure
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({sysResetOut, coreResetOut}, 2'b00);
		t_status();
		t_exit();
		t_lls();
		t_reset();
		t_lowpow();
		t_link();
		t_secure();
		report_and_stop();
	end
	initial begin
		#2ms;
		err_total++;
		report_and_stop();
	end
endmodule : testbench
